/* hdl/bcs_pkg.sv */
// Constants, types and helpers for the baseline sequencing slice.
// Assumes a 10 MHz pclk and a 12-bit program store outside the block.
package bcs_pkg;

  // Program counter and memory variants
  localparam int         PC_W      = 11;
  localparam logic [1:0] VAR_512   = 2'h0;
  localparam logic [1:0] VAR_1K    = 2'h1;
  localparam logic [1:0] VAR_2K    = 2'h2;
  localparam logic [10:0] MASK_512 = 11'h1FF;
  localparam logic [10:0] MASK_1K  = 11'h3FF;
  localparam logic [10:0] MASK_2K  = 11'h7FF;
  localparam logic [10:0] ADDR_ZERO = 11'h000;
  localparam logic [10:0] PC_STEP  = 11'h001;

  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLD_TIME_NS  = 18_000_000;
  localparam int HOLD_CYCLES   =
    (HOLD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] GUARD_LIMIT = 8'hFF;

  // APB register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_ACC   = 8'h08;
  localparam logic [7:0] OFS_FLAGS = 8'h0C;
  localparam logic [7:0] OFS_DIR   = 8'h10;

  // Data file map
  localparam logic [4:0] FA_STATUS = 5'h03;
  localparam logic [4:0] FA_PTR    = 5'h04;
  localparam logic [4:0] FA_DIR5   = 5'h05;
  localparam logic [4:0] FA_DIR6   = 5'h06;
  localparam logic [4:0] FA_DIR7   = 5'h07;
  localparam logic [4:0] FA_BANKED = 5'h10;
  localparam int         FILE_DEPTH = 80;

  // Opcode masks and patterns
  localparam logic [11:0] SUB_MASK  = 12'hFC0;
  localparam logic [11:0] SUB_PAT   = 12'h080;
  localparam logic [11:0] SWAP_PAT  = 12'h380;
  localparam logic [11:0] DIRL_MASK = 12'hFF8;
  localparam logic [11:0] DIRL_PAT  = 12'h000;
  localparam logic [11:0] GOTO_MASK = 12'hE00;
  localparam logic [11:0] GOTO_PAT  = 12'hA00;
  localparam logic [11:0] OP_SLEEP  = 12'h003;
  localparam logic [11:0] OP_GCLEAR = 12'h004;

  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] PTR_RESET    = 8'h00;
  localparam logic [7:0] DIR_RESET    = 8'hFF;
  localparam logic [7:0] BYTE_ZERO    = 8'h00;

  typedef enum logic [1:0] {ST_HOLD, ST_RUN, ST_SLEEP} bcs_state_type;

  typedef struct packed {
    logic [2:0] page;
    logic       timeout_n;
    logic       powerdown_n;
    logic       zero;
    logic       nibble_overflow_flag;
    logic       carry;
  } bcs_status_type;

  // Implemented address mask; doubles as the reset vector
  function automatic logic [10:0] pc_mask(input logic [1:0] variant);
    if (variant == VAR_512) begin
      pc_mask = MASK_512;
    end else if (variant == VAR_1K) begin
      pc_mask = MASK_1K;
    end else begin
      pc_mask = MASK_2K;
    end
  endfunction

endpackage

/* hdl/bcs_hold_timer.sv */
// Reset-hold timer: keeps the core held after reset or restart.
// Assumes a clock enable qualifying every cycle it counts.
`timescale 1ns/1ps
module bcs_hold_timer #(
  parameter int HOLD_CYCLES = bcs_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Control
  input  wire logic restart,
  output logic      busy
);
  localparam int CW = $clog2(HOLD_CYCLES + 1);
  logic [CW-1:0] count;

  assign busy = (count != CW'(HOLD_CYCLES));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (ce) begin
      if (restart) begin
        count <= '0;
      end else if (busy) begin
        count <= CW'(count + 1'b1); // [RULE11]
      end
    end
  end

  a_hold_release: assert property (@(posedge pclk) disable iff (!presetn)
    ce && busy && !restart && count == CW'(HOLD_CYCLES - 1)
      |=> !busy) // [RULE11]
    else $error("hold timer did not release at its count");
endmodule // bcs_hold_timer

/* hdl/bcs_guard_timer.sv */
// Guard timer counting ticks of its own free-running oscillator.
// Assumes osc_tick is already a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ps
module bcs_guard_timer (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic ce,
  // Control
  input  wire logic fuse,
  input  wire logic osc_tick,
  input  wire logic clear,
  output logic      timeout
);
  logic [7:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count   <= bcs_pkg::BYTE_ZERO;
      timeout <= 1'b0;
    end else if (ce) begin
      timeout <= 1'b0;
      // Only the fuse stops it; software reaches here only through clear, which restarts the count
      if (!fuse || clear) begin // [RULE9]
        count <= bcs_pkg::BYTE_ZERO;
      end else if (osc_tick) begin // [RULE10]
        if (count == bcs_pkg::GUARD_LIMIT) begin
          count   <= bcs_pkg::BYTE_ZERO;
          timeout <= 1'b1;
        end else begin
          count <= 8'(count + 8'h01);
        end
      end
    end
  end

  a_guard_fused: assert property (@(posedge pclk) disable iff (!presetn)
    !fuse |=> !timeout) // [RULE9]
    else $error("guard timer fired while fused off");
endmodule // bcs_guard_timer

/* hdl/bcs_core.sv */
// Sequencing slice of a baseline 8-bit core with an APB window.
// Assumes prog_data answers prog_addr within the same cycle.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [RULE1] Smallest variant: 9-bit counter over 512 twelve-bit words.
// [RULE2] Mid variant: 10-bit counter over 1K twelve-bit words.
// [RULE3] Largest variant: 11-bit counter over 2K twelve-bit words.
// [RULE4] Addresses past the implemented size wrap; high bits ignored.
// [RULE5] Start at reset vector; a no-op there rolls over to zero.
// [RULE6] Reset vector is the last word: 1FF, 3FF or 7FF.
// [RULE7] Above 512 words, page bits in status pick the program page.
// [RULE8] Above 32 file registers, pointer upper bits pick the bank.
// [RULE9] Only the configuration fuse can disable the guard timer.
// [RULE10] Guard timer counts its own oscillator, not the core clock.
// [RULE11] Core held about 18 ms after reset for oscillator start.
// [RULE12] Sleep halts execution; wake only by reset or guard timeout.
// [RULE13] Subtract gives file minus accumulator, sets flags, picks dest.
// [RULE14] Nibble swap exchanges halves, picks dest, flags untouched.
// [RULE15] Direction load copies accumulator to register 5, 6 or 7.
// [RULE16] Subtract carry is inverted borrow: set unless underflow.
// [RULE17] These three instructions take one word and one cycle.
module bcs_core #(
  parameter int HOLD_CYCLES = bcs_pkg::HOLD_CYCLES
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Program store
  output logic      [10:0] prog_addr,
  input  wire logic [11:0] prog_data,
  // Guard timer
  input  wire logic        guard_timer_fuse,
  input  wire logic        guard_osc_tick,
  // Port direction registers and status
  output logic      [7:0]  port_dir_5,
  output logic      [7:0]  port_dir_6,
  output logic      [7:0]  port_dir_7,
  output logic             sleeping
);
  bcs_pkg::bcs_state_type  state;
  bcs_pkg::bcs_status_type status;
  logic [10:0] pc;
  logic [10:0] next_pc;
  logic [10:0] mask;
  logic [1:0]  variant;
  logic [7:0]  acc;
  logic [7:0]  file_select_pointer;
  logic [7:0]  file_mem [bcs_pkg::FILE_DEPTH];
  logic        hold_busy;
  logic        timeout;
  logic        exec;
  logic [11:0] instr;
  logic [4:0]  faddr;
  logic        dest_file;
  logic [6:0]  fidx;
  logic [7:0]  fval;
  logic [8:0]  diff;
  logic [4:0]  ndiff;
  logic [7:0]  result;
  logic        subtract_acc_from_file;
  logic        nibble_exchange_op;
  logic        port_direction_load;
  logic        op_goto;
  logic        op_sleep;
  logic        op_gclear;
  logic        wr_file;
  logic        wr_acc;
  logic        apb_wr;
  logic        apb_hit;
  logic [31:0] rd_value;

  // Banked entries follow the 16 unbanked ones
  function automatic logic [6:0] file_index(
    input logic [4:0] f, input logic [7:0] ptr, input logic [1:0] v);
    logic [1:0] bank;
    bank = (v == bcs_pkg::VAR_512) ? 2'h0 : ptr[6:5]; // [RULE8]
    if (f < bcs_pkg::FA_BANKED) begin
      file_index = {3'h0, f[3:0]};
    end else begin
      file_index = 7'(7'h10 + {3'h0, bank, f[3:0]});
    end
  endfunction

  // Sequencing
  assign mask      = bcs_pkg::pc_mask(variant); // [RULE1] [RULE2] [RULE3]
  assign prog_addr = pc;
  assign instr     = prog_data;
  assign sleeping  = (state == bcs_pkg::ST_SLEEP);
  assign exec      = ce && state == bcs_pkg::ST_RUN && !timeout;

  bcs_hold_timer #(
    .HOLD_CYCLES (HOLD_CYCLES)
  ) u_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .restart (timeout),
    .busy    (hold_busy)
  );

  bcs_guard_timer u_guard (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .fuse     (guard_timer_fuse),
    .osc_tick (guard_osc_tick),
    .clear    (exec && (op_gclear || op_sleep)),
    .timeout  (timeout)
  );

  // Decode
  always_comb begin
    faddr     = instr[4:0];
    dest_file = instr[5];
    subtract_acc_from_file =
      (instr & bcs_pkg::SUB_MASK) == bcs_pkg::SUB_PAT;
    nibble_exchange_op =
      (instr & bcs_pkg::SUB_MASK) == bcs_pkg::SWAP_PAT;
    port_direction_load =
      (instr & bcs_pkg::DIRL_MASK) == bcs_pkg::DIRL_PAT &&
      instr[2:0] >= bcs_pkg::FA_DIR5[2:0];
    op_goto   = (instr & bcs_pkg::GOTO_MASK) == bcs_pkg::GOTO_PAT;
    op_sleep  = instr == bcs_pkg::OP_SLEEP;
    op_gclear = instr == bcs_pkg::OP_GCLEAR;
  end

  // Operand fetch and arithmetic
  always_comb begin
    fidx = file_index(faddr, file_select_pointer, variant);
    if (faddr == bcs_pkg::FA_STATUS) begin
      fval = status;
    end else if (faddr == bcs_pkg::FA_PTR) begin
      fval = file_select_pointer;
    end else begin
      fval = file_mem[fidx];
    end
    diff  = 9'({1'b0, fval} - {1'b0, acc}); // [RULE13]
    ndiff = 5'({1'b0, fval[3:0]} - {1'b0, acc[3:0]});
    if (nibble_exchange_op) begin
      result = {fval[3:0], fval[7:4]}; // [RULE14]
    end else begin
      result = diff[7:0];
    end
    wr_file = exec && (subtract_acc_from_file || nibble_exchange_op)
              && dest_file;
    wr_acc  = exec && (subtract_acc_from_file || nibble_exchange_op)
              && !dest_file;
  end

  // Page bits feed jumps; every address folds into the mask
  always_comb begin
    if (op_goto) begin
      next_pc = {status.page[1:0], instr[8:0]} & mask; // [RULE7]
    end else begin
      next_pc = 11'(pc + bcs_pkg::PC_STEP) & mask; // [RULE4] [RULE5]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bcs_pkg::ST_HOLD;
      pc    <= bcs_pkg::ADDR_ZERO;
    end else if (ce) begin
      case (state)
        bcs_pkg::ST_HOLD: begin
          pc <= mask; // [RULE6] [RULE11]
          if (!hold_busy) begin
            state <= bcs_pkg::ST_RUN;
          end
        end
        bcs_pkg::ST_RUN: begin
          if (timeout) begin
            state <= bcs_pkg::ST_HOLD;
          end else begin
            pc <= next_pc; // [RULE17]
            if (op_sleep) begin
              state <= bcs_pkg::ST_SLEEP;
            end
          end
        end
        bcs_pkg::ST_SLEEP: begin
          if (timeout) begin
            state <= bcs_pkg::ST_HOLD; // [RULE12]
          end
        end
        default: begin
          state <= bcs_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // Accumulator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= bcs_pkg::BYTE_ZERO;
    end else if (wr_acc) begin
      acc <= result; // [RULE13] [RULE14]
    end
  end

  // General file registers; no reset, as on the real array
  always_ff @(posedge pclk) begin
    if (wr_file && faddr != bcs_pkg::FA_STATUS
        && faddr != bcs_pkg::FA_PTR) begin
      file_mem[fidx] <= result;
    end
  end

  // File select pointer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_select_pointer <= bcs_pkg::PTR_RESET;
    end else if (wr_file && faddr == bcs_pkg::FA_PTR) begin
      file_select_pointer <= result;
    end
  end

  // Status: arithmetic flags win over a direct write of the register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= bcs_pkg::STATUS_RESET;
    end else if (ce) begin
      if (timeout) begin
        status.timeout_n <= 1'b0;
        status.page      <= 3'h0;
      end else if (exec) begin
        if (wr_file && faddr == bcs_pkg::FA_STATUS) begin
          status.page                 <= result[7:5];
          status.zero                 <= result[2];
          status.nibble_overflow_flag <= result[1];
          status.carry                <= result[0];
        end
        if (subtract_acc_from_file) begin
          status.carry                <= !diff[8]; // [RULE16]
          status.nibble_overflow_flag <= !ndiff[4];
          status.zero <= (diff[7:0] == bcs_pkg::BYTE_ZERO); // [RULE13]
        end
        if (op_gclear || op_sleep) begin
          status.timeout_n   <= 1'b1;
          status.powerdown_n <= !op_sleep;
        end
      end
    end
  end

  // Direction registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_dir_5 <= bcs_pkg::DIR_RESET;
      port_dir_6 <= bcs_pkg::DIR_RESET;
      port_dir_7 <= bcs_pkg::DIR_RESET;
    end else if (exec && port_direction_load) begin
      if (instr[2:0] == bcs_pkg::FA_DIR5[2:0]) begin
        port_dir_5 <= acc; // [RULE15]
      end else if (instr[2:0] == bcs_pkg::FA_DIR6[2:0]) begin
        port_dir_6 <= acc; // [RULE15]
      end else begin
        port_dir_7 <= acc; // [RULE15]
      end
    end
  end

  // APB: zero wait states; read data captured in the setup cycle
  assign pready  = 1'b1;
  assign apb_wr  = psel && penable && pwrite && ce;
  assign pslverr = psel && penable && !apb_hit;

  always_comb begin
    apb_hit  = 1'b1;
    rd_value = 32'h0000_0000;
    if (paddr == bcs_pkg::OFS_CTRL) begin
      rd_value = {30'h0000_0000, variant};
    end else if (paddr == bcs_pkg::OFS_STATE) begin
      rd_value = {14'h0000, sleeping, hold_busy, 5'h00, pc};
    end else if (paddr == bcs_pkg::OFS_ACC) begin
      rd_value = {24'h00_0000, acc};
    end else if (paddr == bcs_pkg::OFS_FLAGS) begin
      rd_value = {24'h00_0000, status};
    end else if (paddr == bcs_pkg::OFS_DIR) begin
      rd_value = {8'h00, port_dir_7, port_dir_6, port_dir_5};
    end else begin
      apb_hit = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (ce && psel && !penable) begin
      prdata <= rd_value;
    end
  end

  // Variant select; reserved code 3 behaves as the largest store
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      variant <= bcs_pkg::VAR_2K;
    end else if (apb_wr && paddr == bcs_pkg::OFS_CTRL) begin
      variant <= pwdata[1:0];
    end
  end

  // Checks
  a_pc_wraps: assert property (@(posedge pclk) disable iff (!presetn)
    state == bcs_pkg::ST_RUN |-> (pc & ~mask) == 11'h000) // [RULE4]
    else $error("program counter outside implemented range");

  a_vector_start: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(state == bcs_pkg::ST_RUN) |-> pc == mask) // [RULE6]
    else $error("execution did not begin at the reset vector");

  a_vector_roll: assert property (@(posedge pclk) disable iff (!presetn)
    exec && pc == mask && instr == 12'h000 && $stable(variant)
      |=> pc == 11'h000) // [RULE5]
    else $error("no-op at last word did not roll to zero");

  a_sub_carry: assert property (@(posedge pclk) disable iff (!presetn)
    exec && subtract_acc_from_file
      |=> status.carry == ($past(fval) >= $past(acc))) // [RULE16]
    else $error("subtract carry is not the inverted borrow");

  a_sub_dest: assert property (@(posedge pclk) disable iff (!presetn)
    exec && subtract_acc_from_file && !dest_file
      |=> acc == 8'($past(fval) - $past(acc))) // [RULE13]
    else $error("subtract result not in accumulator");

  a_swap_value: assert property (@(posedge pclk) disable iff (!presetn)
    exec && nibble_exchange_op && !dest_file
      |=> acc == {$past(fval[3:0]), $past(fval[7:4])}) // [RULE14]
    else $error("nibble swap result wrong");

  a_swap_flags: assert property (@(posedge pclk) disable iff (!presetn)
    exec && nibble_exchange_op && faddr != bcs_pkg::FA_STATUS
      |=> status[2:0] == $past(status[2:0])) // [RULE14]
    else $error("nibble swap altered flags");

  a_dir_load: assert property (@(posedge pclk) disable iff (!presetn)
    exec && port_direction_load && instr[2:0] == 3'h6
      |=> port_dir_6 == $past(acc) && status == $past(status)) // [RULE15]
    else $error("direction load wrong or touched flags");

  a_sleep_halt: assert property (@(posedge pclk) disable iff (!presetn)
    sleeping && !timeout |=> $stable(pc) && $stable(acc)) // [RULE12]
    else $error("core advanced while asleep");

  a_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    exec && (subtract_acc_from_file || port_direction_load)
      |=> pc == (11'($past(pc) + 11'h001) & $past(mask))) // [RULE17]
    else $error("instruction did not finish in one cycle");
endmodule // bcs_core

/* tb/bcs_prog_mem.sv */
// Program store model: 2K twelve-bit words, read in the same cycle.
// Assumes the bench loads and clears words by hierarchical reference.
`timescale 1ns/1ps
module bcs_prog_mem (
  // Fetch port
  input  wire logic [10:0] prog_addr,
  output logic      [11:0] prog_data
);
  logic [11:0] words [0:2047];

  // Full 11-bit decode; the core alone must fold unused high bits
  assign prog_data = words[prog_addr];
endmodule // bcs_prog_mem

/* tb/tb_baseline_cpu_sequencing_slice.sv */
// Bench for the sequencing slice: programs, variants, sleep and guard.
// Assumes the program store model beside the core and a 10 MHz pclk.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin \
  err_total++; $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_baseline_cpu_sequencing_slice;
  // Short hold keeps the run brief
  localparam int HOLD = 20;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [10:0] prog_addr;
  logic [11:0] prog_data;
  logic        fuse = 1'b0;
  logic        tick = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  dir5;
  logic [7:0]  dir6;
  logic [7:0]  dir7;
  logic        sleeping;
  logic [31:0] rd;
  logic        err;
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles = 0;

  always #50 pclk = ~pclk;

  bcs_core #(.HOLD_CYCLES(HOLD)) uut (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .prog_addr(prog_addr), .prog_data(prog_data),
    .guard_timer_fuse(fuse), .guard_osc_tick(tick),
    .port_dir_5(dir5), .port_dir_6(dir6), .port_dir_7(dir7),
    .sleeping(sleeping)
  );

  bcs_prog_mem prog_mem (.prog_addr(prog_addr), .prog_data(prog_data));

  task automatic report_and_stop();
    $display("Checks %0d, errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // A hang anywhere ends here as a mismatch
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 10000) begin
      err_total++;
      report_and_stop();
    end
  end

  task automatic apb(input logic [7:0] a, input logic w,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic restart_all();
    presetn <= 1'b0;
    for (int i = 0; i < 2048; i++) prog_mem.words[i] = 12'h000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge pclk);
      tick <= 1'b1;
      @(posedge pclk);
      tick <= 1'b0;
    end
  endtask

  // Sees the vector held, then the no-op there rolling over to zero
  task automatic await_start(input logic [10:0] vec, output int t);
    t = 2;
    repeat (2) @(posedge pclk);
    `CHK("hold vector", vec, prog_addr)
    while (prog_addr !== 11'h000 && t < 80) begin
      @(posedge pclk);
      t++;
    end
    `CHK("rollover to zero", 11'h000, prog_addr)
  endtask

  task automatic run_prog(input logic [107:0] p, input int n,
                          input logic [7:0] acc, input logic [7:0] flg,
                          input logic [23:0] dirs);
    int t;
    restart_all();
    for (int i = 0; i < 9; i++) prog_mem.words[i] = p[(8-i)*12 +: 12];
    await_start(11'h7FF, t);
    `CHK("hold length", 1'b1, (t >= HOLD && t <= HOLD + 4))
    for (int i = 1; i <= n; i++) begin
      @(posedge pclk);
      `CHK("fetch step", 11'(i), prog_addr)
    end
    // Accumulator is read-only over the bus; this write must vanish
    apb(bcs_pkg::OFS_ACC, 1'b1, 32'h0000_00FF);
    apb(bcs_pkg::OFS_ACC, 1'b0, 32'h0);
    `CHK("acc", acc, rd[7:0])
    apb(bcs_pkg::OFS_FLAGS, 1'b0, 32'h0);
    `CHK("flags", flg, rd[7:0])
    apb(bcs_pkg::OFS_DIR, 1'b0, 32'h0);
    `CHK("dir reg", dirs, rd[23:0])
    `CHK("dir pins", dirs, {dir7, dir6, dir5})
  endtask

  // Guard restart applies the new vector; a jump to 1FE then wraps to zero in the 512-word variant only
  task automatic variant_wrap(input logic [1:0] v);
    logic [10:0] mask;
    int          t;
    mask = (v == 2'h0) ? 11'h1FF : (v == 2'h1) ? 11'h3FF : 11'h7FF;
    restart_all();
    prog_mem.words[0] = 12'hBFE;
    apb(bcs_pkg::OFS_CTRL, 1'b1, {30'h0, v});
    apb(bcs_pkg::OFS_CTRL, 1'b0, 32'h0);
    `CHK("ctrl", v, rd[1:0])
    fuse <= 1'b1;
    ticks(256);
    fuse <= 1'b0;
    @(posedge pclk);
    await_start(mask, t);
    @(posedge pclk);
    `CHK("jump", 11'h1FE & mask, prog_addr)
    repeat (2) @(posedge pclk);
    `CHK("wrap", 11'h200 & mask, prog_addr)
  endtask

  // Page bits written through status steer a jump; ce low freezes all
  task automatic page_jump();
    logic [10:0] held;
    int          t;
    restart_all();
    prog_mem.words[0] = 12'h083;
    prog_mem.words[1] = 12'h3A3;
    prog_mem.words[2] = 12'hA05;
    await_start(11'h7FF, t);
    repeat (3) @(posedge pclk);
    `CHK("page jump", 11'h205, prog_addr)
    apb(bcs_pkg::OFS_FLAGS, 1'b0, 32'h0);
    `CHK("page bits", 8'hB9, rd[7:0])
    ce <= 1'b0;
    repeat (3) @(posedge pclk);
    held = prog_addr;
    repeat (3) @(posedge pclk);
    `CHK("frozen", held, prog_addr)
    ce <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("resumed", 11'(held + 11'h001), prog_addr)
  endtask

  task automatic sleep_guard();
    logic [10:0] held;
    int          t;
    restart_all();
    prog_mem.words[1] = 12'h004;
    prog_mem.words[2] = 12'h003;
    await_start(11'h7FF, t);
    repeat (3) @(posedge pclk);
    held = prog_addr;
    `CHK("asleep", 1'b1, sleeping)
    ticks(300);
    `CHK("fuse off", 1'b1, sleeping)
    `CHK("halted", held, prog_addr)
    fuse <= 1'b1;
    repeat (40) @(posedge pclk);
    `CHK("core clock only", 1'b1, sleeping)
    ticks(255);
    `CHK("below limit", 1'b1, sleeping)
    ticks(1);
    fuse <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(bcs_pkg::OFS_STATE, 1'b0, 32'h0);
    `CHK("hold busy", 1'b1, rd[16])
    apb(bcs_pkg::OFS_FLAGS, 1'b0, 32'h0);
    `CHK("timeout flag", 1'b0, rd[4])
    await_start(11'h7FF, t);
    `CHK("woken", 1'b0, sleeping)
    // Guard clear at word 1 restores both flags before the next sleep
    apb(bcs_pkg::OFS_FLAGS, 1'b0, 32'h0);
    `CHK("guard clear", 2'b11, rd[4:3])
  endtask

  initial begin
    run_prog({12'h383, 12'h084, 12'hA02, 72'h0}, 2,
             8'h7F, 8'h18, 24'hFFFFFF);
    run_prog({12'h084, 12'h383, 12'h007, 12'hA03, 60'h0}, 3,
             8'hF1, 8'h1F, 24'hF1FFFF);
    run_prog({12'h383, 12'h084, 12'h0A4, 12'h384, 12'h0A4, 12'h384,
              12'h005, 12'h006, 12'hA08}, 8, 8'h96, 8'h19, 24'hFF9696);
    for (int v = 0; v < 4; v++) variant_wrap(2'(v));
    page_jump();
    sleep_guard();
    // Unmapped offset answers with an error and zero data
    apb(8'h14, 1'b0, 32'h0);
    `CHK("slave error", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    report_and_stop();
  end
endmodule // tb_baseline_cpu_sequencing_slice
